// file: common/dbg_break_pkg.sv
/*
 * Shared constants for the multi-core debug break and event block.
 * Assumes a single core clock domain and a synchronous active-low reset.
 */
package dbg_break_pkg;

    // ----------------------------------------------------------------
    // Core count and widths
    // ----------------------------------------------------------------
    localparam int         NUM_CORES      = 2;
    localparam int         DBG_INFO_W     = 32;
    localparam int         ACC_SIZE_W     = 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] DBG_INFO_RST   = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Access size encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] ACC_SIZE_8     = 2'h0;
    localparam logic [1:0] ACC_SIZE_16    = 2'h1;
    localparam logic [1:0] ACC_SIZE_32    = 2'h2;
    localparam logic [1:0] ACC_SIZE_64    = 2'h3;

    // ----------------------------------------------------------------
    // Flash rewrite sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        FW_IDLE,
        FW_SAVE,
        FW_PROG,
        FW_RESTORE
    } flash_state_e;

endpackage

// file: verilog/sync2.sv
/*
 * Two flip-flop synchroniser for a single level from outside the clock.
 * Assumes the input is a slowly changing level, not a pulse.
 */
`timescale 1ns/10ps
module sync2
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // Level in and out
    input  wire logic din,
    output logic      dout
);
    typedef struct packed
    {
        logic stage1;
        logic stage2;
    } sync_s;

    sync_s st_ff;
    sync_s nxt_st;

    // ----------------------------------------------------------------
    // Next state: first stage read only by the second
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_st        = st_ff;
        nxt_st.stage1 = din;
        nxt_st.stage2 = st_ff.stage1;
    end

    // Registers
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign dout = st_ff.stage2;
endmodule

// file: verilog/access_event_unit.sv
/*
 * Access event matcher for one bus port of the primary core.
 * Assumes access strobes are single-cycle pulses on the core clock.
 */
`timescale 1ns/10ps
module access_event_unit
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // Event setup
    input  wire logic        ev_enable,
    input  wire logic        ev_is_read,
    input  wire logic        ev_use_data,
    input  wire logic [31:0] ev_addr,
    input  wire logic [31:0] ev_data,
    // Observed access
    input  wire logic        acc_valid,
    input  wire logic        acc_write,
    input  wire logic [31:0] acc_addr,
    input  wire logic [31:0] acc_data,
    input  wire logic        acc_rmw_write,
    input  wire logic        acc_blind,
    // Match
    output logic             ev_hit
);
    typedef struct packed
    {
        logic hit;
    } ev_s;

    ev_s st_ff;
    ev_s nxt_st;
    logic match;

    // ----------------------------------------------------------------
    // Match logic
    // ----------------------------------------------------------------
    always_comb
    begin
        match = ev_enable && acc_valid && !acc_blind            // R14
             && (acc_write != ev_is_read)
             && (acc_addr == ev_addr)
             && (!ev_use_data || acc_data == ev_data);
        // Data-conditioned events never see the RMW write half
        if (ev_use_data && acc_rmw_write && acc_write)
            match = 1'b0;                                       // R13
        nxt_st     = st_ff;
        nxt_st.hit = match;
    end

    // Registers
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign ev_hit = st_ff.hit;

    a_rmw_no_hit: assert property (@(posedge mclk) disable iff (!resetn)
        (ev_use_data && acc_rmw_write && acc_write) |=> !ev_hit) // R13
        else $error("rmw write matched a data event");
    a_blind_no_hit: assert property (@(posedge mclk) disable iff (!resetn)
        acc_blind |=> !ev_hit)                                  // R14
        else $error("blind access produced an event");
endmodule

// file: verilog/debug_break_ctrl.sv
/*
 * Debug break and event control for a multi-core controller.
 * Assumes the probe command strobes are on mclk; pins are synchronised.
 */
// Functional notes
// [R1] Refuse hot attach while reset pin held or in power shutoff standby.
// [R2] Async debug mode: peripheral freeze-on-break never takes effect.
// [R3] Async debug mode: ignore reset requests while any core is in break; the code gates only user_reset_req, debugger reset is still taken.
// [R4] Async debug mode: freeze both watchdog counters while any core breaks.
// [R5] Coincident run ECC error and halted-core debugger access is suppressed.
// [R6] Halted-core debugger access breaks a concurrent protected write.
// [R7] Debugger spaces section measurement start and end widely enough.
// [R8] Debugger working area is 4 or 9 KB at top of local RAM.
// [R9] Working RAM saved and restored; system keeps other masters away.
// [R10] Flash rewrite sets PLL undivided; refused above clock monitor limit.
// [R11] Flash programming fails if break hit clock-setting code.
// [R12] Debugger never sets 64-bit access-size event conditions.
// [R13] Primary core RMW write half never matches a data-conditioned event.
// [R14] Access right after bit or cache instruction produces no event.
// [R15] Two global RAM banks give at most two events per cycle.
// [R16] Read event just before forced or event break rebreaks on resume.
// [R17] Overwritten software break instruction produces no break.
// [R18] Debug information clears to zero on any reset.
// [R19] Debugger reset always resets cores, then breaks every core.
// [R20] Per-core break states ORed for reset gating and watchdog freeze.
`timescale 1ns/10ps
module debug_break_ctrl
#(
    parameter int NCORE = dbg_break_pkg::NUM_CORES
)
(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             resetn,
    // Device pins and power state
    input  wire logic             rst_pin_n,
    input  wire logic             standby_off,
    input  wire logic             attach_req,
    // Modes and per-core break state
    input  wire logic             async_mode,
    input  wire logic [NCORE-1:0] core_break,
    input  wire logic             periph_freeze_en,
    // Reset sources
    input  wire logic             user_reset_req,
    input  wire logic             dbg_reset_req,
    // Flash rewrite control
    input  wire logic             flash_req,
    input  wire logic             pll_over_limit,
    input  wire logic             in_clock_setup,
    input  wire logic             save_done,
    input  wire logic             prog_done,
    input  wire logic             restore_done,
    // Shared resource accesses
    input  wire logic             run_ecc_err,
    input  wire logic             run_flash_acc,
    input  wire logic             halt_dbg_acc,
    input  wire logic             prot_seq_step,
    // Break requests
    input  wire logic             brk_forced,
    input  wire logic             brk_event,
    input  wire logic             resume,
    input  wire logic             swbrk_fetch,
    input  wire logic             swbrk_intact,
    // Access events, primary core
    input  wire logic             ev_enable,
    input  wire logic             ev_is_read,
    input  wire logic             ev_use_data,
    input  wire logic [31:0]      ev_addr,
    input  wire logic [31:0]      ev_data,
    input  wire logic [1:0]       acc_valid,
    input  wire logic [1:0]       acc_write,
    input  wire logic [63:0]      acc_addr,
    input  wire logic [63:0]      acc_data,
    input  wire logic             acc_rmw_write,
    input  wire logic             prev_bit_or_cache,
    // Debug information
    input  wire logic             dbg_info_wr,
    input  wire logic [31:0]      dbg_info_wdata,
    // Outputs
    output logic                  attach_ok,
    output logic                  attach_refused,
    output logic                  periph_freeze,
    output logic                  core_reset,
    output logic                  break_all,
    output logic                  wdt_a_freeze,
    output logic                  wdt_b_freeze,
    output logic                  ecc_err_out,
    output logic                  prot_seq_abort,
    output logic                  pll_undivided,
    output logic                  flash_busy,
    output logic                  flash_fail,
    output logic [1:0]            ev_hits,
    output logic                  rebreak,
    output logic                  sw_break,
    output logic [31:0]           dbg_info
);
    initial
    begin
        if (NCORE < 1 || NCORE > 8)
            $error("NCORE must be 1 to 8");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic                        attach_ok;
        logic                        attach_refused;
        logic                        periph_freeze;
        logic                        core_reset;
        logic                        break_all;
        logic                        wdt_freeze;
        logic                        ecc_err;
        logic                        prot_abort;
        logic                        pll_undiv;
        logic                        flash_fail;
        dbg_break_pkg::flash_state_e fstate;
        logic                        rd_pending;
        logic                        rebreak;
        logic                        sw_break;
        logic                        dbg_rst_seen;
        logic [31:0]                 dbg_info;
    } ctrl_s;

    ctrl_s st_ff;
    ctrl_s nxt_st;

    logic       rst_pin_s;
    logic       standby_s;
    logic       any_break;
    logic [1:0] hit;
    logic       clk_setup_brk;

    // Pin level synchronisers
    sync2 u_sync_rst
    (
        .mclk   (mclk),
        .resetn (resetn),
        .din    (rst_pin_n),
        .dout   (rst_pin_s)
    );
    sync2 u_sync_stby
    (
        .mclk   (mclk),
        .resetn (resetn),
        .din    (standby_off),
        .dout   (standby_s)
    );

    // ----------------------------------------------------------------
    // Global RAM bank event matchers
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_bank
            // One matcher per bank, so two hits per cycle at most
            access_event_unit u_ev                              // R15
            (
                .mclk          (mclk),
                .resetn        (resetn),
                .ev_enable     (ev_enable),
                .ev_is_read    (ev_is_read),
                .ev_use_data   (ev_use_data),
                .ev_addr       (ev_addr),
                .ev_data       (ev_data),
                .acc_valid     (acc_valid[g]),
                .acc_write     (acc_write[g]),
                .acc_addr      (acc_addr[32*g +: 32]),
                .acc_data      (acc_data[32*g +: 32]),
                .acc_rmw_write (acc_rmw_write),
                .acc_blind     (prev_bit_or_cache),
                .ev_hit        (hit[g])
            );
        end
    endgenerate

    // Break state of all cores merged
    assign any_break = |core_break;                             // R20
    assign clk_setup_brk = in_clock_setup && any_break;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;

        // Attach refused under reset pin or power shutoff
        nxt_st.attach_ok      = attach_req && rst_pin_s && !standby_s; // R1
        nxt_st.attach_refused = attach_req && (!rst_pin_s || standby_s);

        // Freeze only honoured in synchronous mode
        nxt_st.periph_freeze = periph_freeze_en && any_break
                             && !async_mode;                    // R2

        // Debugger reset wins over masking; user reset gated
        nxt_st.core_reset = dbg_reset_req                       // R19
            || (user_reset_req && !(async_mode && any_break));  // R3
        if (dbg_reset_req)
            nxt_st.dbg_rst_seen = 1'b1;
        // Break all cores once the debugger reset is released
        nxt_st.break_all = st_ff.dbg_rst_seen && !dbg_reset_req; // R19
        if (nxt_st.break_all)
            nxt_st.dbg_rst_seen = 1'b0;

        nxt_st.wdt_freeze = async_mode && any_break;            // R4

        // Debugger access hides a coincident flash access error of the running core
        nxt_st.ecc_err = run_ecc_err
                       && !(run_flash_acc && halt_dbg_acc);     // R5
        nxt_st.prot_abort = prot_seq_step && halt_dbg_acc;      // R6

        // Flash rewrite sequence with working RAM save and restore
        case (st_ff.fstate)
            dbg_break_pkg::FW_IDLE:
            begin
                if (flash_req)
                begin
                    nxt_st.flash_fail = 1'b0;
                    if (clk_setup_brk)
                        nxt_st.flash_fail = 1'b1;               // R11
                    else
                    begin
                        nxt_st.pll_undiv = 1'b1;                // R10
                        nxt_st.fstate    = dbg_break_pkg::FW_SAVE; // R9
                    end
                end
            end
            dbg_break_pkg::FW_SAVE:
            begin
                if (pll_over_limit)
                begin
                    nxt_st.flash_fail = 1'b1;                   // R10
                    nxt_st.fstate     = dbg_break_pkg::FW_RESTORE;
                end
                else if (save_done)
                    nxt_st.fstate = dbg_break_pkg::FW_PROG;
            end
            dbg_break_pkg::FW_PROG:
            begin
                if (pll_over_limit)
                    nxt_st.flash_fail = 1'b1;                   // R10
                if (prog_done || pll_over_limit)
                    nxt_st.fstate = dbg_break_pkg::FW_RESTORE;  // R9
            end
            dbg_break_pkg::FW_RESTORE:
            begin
                if (restore_done)
                begin
                    nxt_st.pll_undiv = 1'b0;
                    nxt_st.fstate    = dbg_break_pkg::FW_IDLE;
                end
            end
            default:
                nxt_st.fstate = dbg_break_pkg::FW_IDLE;
        endcase

        // Read event just before a break is replayed; arming beats clear
        nxt_st.rebreak = resume && st_ff.rd_pending;            // R16
        if (resume)
            nxt_st.rd_pending = 1'b0;
        if ((|hit) && ev_is_read && (brk_forced || brk_event))
            nxt_st.rd_pending = 1'b1;                           // R16

        // Overwritten break instruction is just ordinary code
        nxt_st.sw_break = swbrk_fetch && swbrk_intact;          // R17

        // Debug information written by the debugger only
        if (dbg_info_wr)
            nxt_st.dbg_info = dbg_info_wdata;
        if (nxt_st.core_reset)
            nxt_st.dbg_info = dbg_break_pkg::DBG_INFO_RST;      // R18
    end

    // Registers; any device reset clears debug information
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            st_ff          <= '0;
            st_ff.fstate   <= dbg_break_pkg::FW_IDLE;
            st_ff.dbg_info <= dbg_break_pkg::DBG_INFO_RST;      // R18
        end
        else
            st_ff <= nxt_st;
    end

    // ----------------------------------------------------------------
    // Outputs, straight from flip-flops except flash_busy, decoded from fstate
    // ----------------------------------------------------------------
    assign attach_ok      = st_ff.attach_ok;
    assign attach_refused = st_ff.attach_refused;
    assign periph_freeze  = st_ff.periph_freeze;
    assign core_reset     = st_ff.core_reset;
    assign break_all      = st_ff.break_all;
    assign wdt_a_freeze   = st_ff.wdt_freeze;
    assign wdt_b_freeze   = st_ff.wdt_freeze;
    assign ecc_err_out    = st_ff.ecc_err;
    assign prot_seq_abort = st_ff.prot_abort;
    assign pll_undivided  = st_ff.pll_undiv;
    assign flash_busy     = (st_ff.fstate != dbg_break_pkg::FW_IDLE);
    assign flash_fail     = st_ff.flash_fail;
    assign ev_hits        = hit;
    assign rebreak        = st_ff.rebreak;
    assign sw_break       = st_ff.sw_break;
    assign dbg_info       = st_ff.dbg_info;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_attach_refuse: assert property (@(posedge mclk) disable iff (!resetn)
        attach_ok |-> $past(rst_pin_s) && !$past(standby_s)) // R1
        else $error("attach accepted in reset or standby");
    a_freeze_async: assert property (@(posedge mclk) disable iff (!resetn)
        $past(async_mode) |-> !periph_freeze)                   // R2
        else $error("peripheral frozen in async mode");
    a_reset_gated: assert property (@(posedge mclk) disable iff (!resetn)
        (async_mode && any_break && !dbg_reset_req) |=> !core_reset) // R3
        else $error("reset taken during async break");
    a_wdt_frozen: assert property (@(posedge mclk) disable iff (!resetn)
        (async_mode && any_break) |=> (wdt_a_freeze && wdt_b_freeze)) // R4
        else $error("watchdog not frozen");
    a_ecc_hidden: assert property (@(posedge mclk) disable iff (!resetn)
        (run_flash_acc && halt_dbg_acc) |=> !ecc_err_out)       // R5
        else $error("ecc error not suppressed");
    a_prot_abort: assert property (@(posedge mclk) disable iff (!resetn)
        (prot_seq_step && halt_dbg_acc) |=> prot_seq_abort)     // R6
        else $error("protected sequence not broken");
    a_clk_setup_fail: assert property (@(posedge mclk) disable iff (!resetn)
        (!flash_busy && flash_req && clk_setup_brk)
            |=> flash_fail && !flash_busy)                      // R11
        else $error("flash started in clock setup");
    a_dbg_reset: assert property (@(posedge mclk) disable iff (!resetn)
        dbg_reset_req ##1 !dbg_reset_req |=> break_all)         // R19
        else $error("no break after debugger reset");
    a_info_clear: assert property (@(posedge mclk) disable iff (!resetn)
        core_reset |-> dbg_info == 32'h0000_0000)               // R18
        else $error("debug info not cleared");
    a_sw_break: assert property (@(posedge mclk) disable iff (!resetn)
        !swbrk_intact |=> !sw_break)                            // R17
        else $error("break from overwritten location");
endmodule

// file: tb/dbg_probe_model.sv
/*
 * Probe model answering the flash rewrite handshake.
 * Assumes the core clock; drives on falling edges.
 */
`timescale 1ns/10ps
module dbg_probe_model
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // Pace and device status
    input  wire logic [3:0] lat,
    input  wire logic       flash_busy,
    // Handshake pulses
    output logic            save_done,
    output logic            prog_done,
    output logic            restore_done
);
    int step;
    int wait_cnt;

    // Quiet before first edge
    initial {save_done, prog_done, restore_done} = 3'h0;

    // --------------------------------------------------------------
    // Save, program, restore in order, each after lat idle cycles
    // --------------------------------------------------------------
    always @(negedge mclk)
    begin
        {save_done, prog_done, restore_done} <= 3'h0;
        if (!resetn || !flash_busy)
        begin
            step     <= 0;
            wait_cnt <= 0;
        end
        else if (step < 3 && wait_cnt < int'(lat))
            wait_cnt <= wait_cnt + 1; // Slow probe stalls here
        else if (step < 3)
        begin
            save_done    <= (step == 0);
            prog_done    <= (step == 1);
            restore_done <= (step == 2);
            step         <= step + 1;
            wait_cnt     <= 0;
        end
    end
endmodule

// file: tb/multicore_debug_break_control_tb.sv
/*
 * Self-checking bench for the debug break and event control block.
 * Assumes a 100 MHz core clock; inputs change on falling edges.
 */
`timescale 1ns/10ps
module multicore_debug_break_control_tb;
    // --------------------------------------------------------------
    // Stimulus and observed signals
    // --------------------------------------------------------------
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        rst_pin_n, standby_off, attach_req, async_mode;
    logic        periph_freeze_en, user_reset_req, dbg_reset_req;
    logic        flash_req, pll_over_limit, in_clock_setup;
    logic        run_ecc_err, run_flash_acc, halt_dbg_acc, prot_seq_step;
    logic        brk_forced, brk_event, resume, swbrk_fetch, swbrk_intact;
    logic        ev_enable, ev_is_read, ev_use_data, acc_rmw_write;
    logic        prev_bit_or_cache, dbg_info_wr;
    logic        save_done, prog_done, restore_done;
    logic [1:0]  core_break, acc_valid, acc_write, ev_hits;
    logic [3:0]  lat;
    logic [31:0] ev_addr, ev_data, dbg_info_wdata, dbg_info, r;
    logic [63:0] acc_addr, acc_data;
    logic        attach_ok, attach_refused, periph_freeze, core_reset;
    logic        break_all, wdt_a_freeze, wdt_b_freeze, ecc_err_out;
    logic        prot_seq_abort, pll_undivided, flash_busy, flash_fail;
    logic        rebreak, sw_break;
    logic [6:0]  e;
    logic [31:0] seed = 32'h0000_07be;
    int          n_fail = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          n;
    localparam logic [11:0] ev_cases = 12'h54b;

    debug_break_ctrl i_dut (.*);
    dbg_probe_model i_probe (.*);

    // Free-running core clock
    always #5 mclk = ~mclk;

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected match of one bank, worked out from the setup
    function automatic logic hit(input int b);
        return ev_enable && acc_valid[b] && !prev_bit_or_cache
            && acc_addr[b*32 +: 32] == ev_addr && acc_write[b] != ev_is_read
            && (!ev_use_data || (acc_data[b*32 +: 32] == ev_data
            && !(acc_write[b] && acc_rmw_write)));
    endfunction

    task automatic tick(input int k);
        repeat (k) @(negedge mclk);
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail++;
            results();
        end
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        {standby_off, attach_req, async_mode, periph_freeze_en,
         user_reset_req, dbg_reset_req, flash_req, pll_over_limit,
         in_clock_setup, run_ecc_err, run_flash_acc, halt_dbg_acc,
         prot_seq_step, brk_forced, brk_event, resume, swbrk_fetch,
         swbrk_intact, ev_enable, ev_is_read, ev_use_data, acc_rmw_write,
         prev_bit_or_cache, dbg_info_wr, core_break, acc_valid,
         acc_write, lat, ev_addr, ev_data, dbg_info_wdata, acc_addr,
         acc_data} = '0;
        rst_pin_n = 1'b1;
        tick(4);
        resetn = 1'b1;
        tick(3);
        // Attach through clean pins, standby, then held reset pin
        attach_req = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            {rst_pin_n, standby_off} = k[1:0] ^ 2'h2;
            tick(5);
            chk({attach_ok, attach_refused}, {k == 0, k != 0});
        end
        // Random modes, breaks and accesses; 32-bit events only
        ev_addr = rnd();
        ev_data = rnd();
        repeat (400)
        begin
            r = rnd();
            {async_mode, periph_freeze_en, run_ecc_err, run_flash_acc,
             halt_dbg_acc, prot_seq_step, swbrk_fetch, swbrk_intact,
             user_reset_req, acc_rmw_write, ev_is_read, ev_use_data,
             acc_valid, acc_write, core_break} = r[17:0];
            prev_bit_or_cache = &r[19:18];
            ev_enable = |r[21:20];
            acc_addr = {r[22] ? ev_addr : ~ev_addr, r[23] ? ev_addr : r};
            acc_data = {r[24] ? ev_data : ~ev_data, r[25] ? ev_data : r};
            e = {!async_mode && periph_freeze_en && |core_break,
                 user_reset_req && !(async_mode && |core_break),
                 run_ecc_err && !(run_flash_acc && halt_dbg_acc),
                 prot_seq_step && halt_dbg_acc,
                 swbrk_fetch && swbrk_intact, hit(1), hit(0)};
            tick(1);
            chk({periph_freeze, core_reset, ecc_err_out, prot_seq_abort,
                 sw_break, ev_hits}, e);
            if (async_mode)
                chk({wdt_a_freeze, wdt_b_freeze}, {2{|core_break}});
        end
        // Both banks at once: RMW and blind blocks, each followed by a hit
        {user_reset_req, ev_enable, ev_is_read} = 3'h2;
        {acc_valid, acc_write} = 4'hf;
        acc_addr = {2{ev_addr}};
        acc_data = {2{ev_data}};
        for (int k = 0; k < 4; k++)
        begin
            {prev_bit_or_cache, acc_rmw_write, ev_use_data} = ev_cases[k*3 +: 3];
            tick(1);
            chk(ev_hits, {2{k[0]}});
        end
        // Read event armed by a forced or event break, then resumes
        {prev_bit_or_cache, ev_use_data, ev_is_read, acc_write} = 5'h4;
        for (int k = 0; k < 2; k++)
        begin
            {brk_event, brk_forced} = k ? 2'h2 : 2'h1;
            acc_valid = 2'h1;
            tick(1);
            acc_valid = 2'h0;
            tick(1);
            {brk_event, brk_forced, resume} = 3'h1;
            tick(1);
            chk(rebreak, 1'b1);
            tick(1);
            chk(rebreak, 1'b0);
            resume = 1'b0;
        end
        // Debug word survives a gated reset, clears on debugger reset
        dbg_info_wdata = rnd();
        dbg_info_wr = 1'b1;
        tick(1);
        dbg_info_wr = 1'b0;
        {async_mode, core_break, user_reset_req} = 4'hb;
        tick(2);
        chk({core_reset, dbg_info}, {1'b0, dbg_info_wdata});
        dbg_reset_req = 1'b1;
        tick(2);
        chk({core_reset, dbg_info}, 64'h1_0000_0000);
        {dbg_reset_req, user_reset_req} = 2'h0;
        n = 0;
        repeat (4)
        begin
            tick(1);
            n += int'(break_all === 1'b1);
        end
        chk(n, 1);
        // Flash rewrite: clean, over clock limit, break in clock setup
        core_break = 2'h1;
        for (int k = 0; k < 3; k++)
        begin
            pll_over_limit = (k == 1);
            in_clock_setup = (k == 2);
            lat = 4'(k * 3);
            flash_req = 1'b1;
            tick(1);
            flash_req = 1'b0;
            chk({flash_busy, pll_undivided}, {2{k != 2}});
            n = 0;
            while (flash_busy === 1'b1 && n < 50)
            begin
                tick(1);
                n++;
            end
            chk({flash_busy, pll_undivided, flash_fail}, k != 0);
        end
        results();
    end
endmodule
